// >>> rsl_params.svh
`ifndef RSL_PARAMS_SVH
`define RSL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register word indices on the Avalon-MM slave (one 32-bit word each)
// ----------------------------------------------------------------------
`define RSL_OFS_CTRL      4'h0
`define RSL_OFS_SEL       4'h1
`define RSL_OFS_M0        4'h2
`define RSL_OFS_M1        4'h3
`define RSL_OFS_MOVF0     4'h4
`define RSL_OFS_MOVF1     4'h5
`define RSL_OFS_MOVF2     4'h6
`define RSL_OFS_IRQF      4'h7
`define RSL_OFS_IRQM      4'h8
`define RSL_OFS_EVTCFG    4'h9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSL_CTRL_GO       0
`define RSL_CTRL_LATCH    1
`define RSL_CTRL_SYNC     2
`define RSL_CTRL_STATE    3
`define RSL_SEL_CNT_LSB   0
`define RSL_SEL_OVF_LSB   4
`define RSL_EVT1_LSB      0
`define RSL_EVT2_LSB      4

// ----------------------------------------------------------------------
// Window select codes and event selector codes
// ----------------------------------------------------------------------
`define RSL_WIN_COUNT     3'h0
`define RSL_WIN_CAPTURE   3'h1
`define RSL_WIN_PERIOD    3'h2
`define RSL_WIN_CMP1      3'h3
`define RSL_WIN_CMP2      3'h4
`define RSL_EVT_NONE      4'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RSL_TIM_RST       16'h0000
`define RSL_OVF_RST       24'h00_0000

`endif

// >>> rsl_pkg.sv
package rsl_pkg;

    // Timer run state.
    typedef enum logic {
        RSL_IDLE,
        RSL_RUN
    } rsl_state_e;

    // The eight timer events; the last field is bit 0 of the flag byte.
    typedef struct packed {
        logic long_cmp2;
        logic long_cmp1;
        logic ovf_cmp2;
        logic ovf_cmp1;
        logic ovf_per;
        logic tim_cmp2;
        logic tim_cmp1;
        logic tim_ovf;
    } rsl_evt_s;

endpackage

// >>> rsl_radio_slot_timer.sv
`timescale 1ns/1ps
`include "rsl_params.svh"

// Overview of operation
// R1: Idle after reset; go bit starts it.
// R2: Writing go bit zero returns to idle.
// R3: Start/stop immediate or on slow tick.
// R4: Count increments each cycle while running.
// R5: Low count read latches high byte.
// R6: Idle count load, low byte first.
// R7: Count at period clears; overflow flag set.
// R8: Running count write freezes, loads delta.
// R9: Delta decrements, stops at zero.
// R10: Count equals compare sets compare flag.
// R11: Each timer overflow increments overflow counter.
// R12: Joint latch captures whole timestamp.
// R13: Low overflow read latches upper bytes.
// R14: Overflow write applies on top byte.
// R15: Overflow counter at period clears, flags.
// R16: Overflow compares set their flags.
// R17: Forty-bit long compares set flags.
// R18: Capture event stores count and overflow.
// R19: Flags set by hardware, cleared by software.
// R20: Two event outputs pick any event.
// R21: Window select codes map internal registers.
// R22: Internal registers reset to zero.
// R23: Interrupt is OR of masked flags.
// R24: Event selector has none code, pulses.
module rsl_radio_slot_timer (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        slow_tick,
    input  wire logic        capture_in,
    output logic             irq,
    output logic             event_out_one,
    output logic             event_out_two
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rsl_pkg::rsl_state_e state;          // Run state.
    rsl_pkg::rsl_state_e next_state;     // Next run state.
    rsl_pkg::rsl_evt_s   evt;            // Events of this cycle.
    logic        go_bit;                 // Software run request.
    logic        joint_latch_select;     // Timestamp latch mode.
    logic        sync_mode;              // Align start/stop to slow tick.
    logic [2:0]  count_window_select;    // Window for the count ports.
    logic [2:0]  overflow_window_select; // Window for the overflow ports.
    logic [15:0] tim;                    // The 16-bit up-counter.
    logic [15:0] tim_cap;                // Captured count.
    logic [15:0] tim_per;                // Count period.
    logic [15:0] tim_cmp1;               // Count compare one.
    logic [15:0] tim_cmp2;               // Count compare two.
    logic [15:0] delta;                  // Delta stretch counter.
    logic [23:0] ovf;                    // Overflow counter.
    logic [23:0] ovf_cap;                // Captured overflow count.
    logic [23:0] ovf_per;                // Overflow period.
    logic [23:0] ovf_cmp1;               // Overflow compare one.
    logic [23:0] ovf_cmp2;               // Overflow compare two.
    logic [7:0]  tim_hi_latch;           // Latched high count byte.
    logic [15:0] ovf_hi_latch;           // Latched upper overflow bytes.
    logic [7:0]  ovf_lo_latch;           // Latched low overflow byte.
    logic [7:0]  cnt_lo_stage;           // Low byte waiting for the high write.
    logic [15:0] ovf_lo_stage;           // Two low bytes waiting for the top write.
    logic [7:0]  irq_flag_reg;           // Sticky event flags.
    logic [7:0]  irq_mask_reg;           // Interrupt masks.
    logic [3:0]  event_out_one_select;   // Selector for event output one.
    logic [3:0]  event_out_two_select;   // Selector for event output two.
    logic        rd_take;                // Read taken this cycle.
    logic        wr_take;                // Write taken this cycle.
    logic        wr_byte;                // Write carrying the low byte lane.
    logic [3:0]  reg_idx;                // Word index of the access.
    logic [7:0]  wbyte;                  // Written byte.
    logic        tick;                   // Count advances this cycle.
    logic        m1_write;               // High count port written.
    logic        movf2_write;            // Top overflow port written.
    logic [15:0] cnt_word;               // Assembled 16-bit write value.
    logic [23:0] ovf_word;               // Assembled 24-bit write value.
    logic [7:0]  next_rdata;             // Read value of the addressed port.
    logic [15:0] cnt_win;                // Count window contents.
    logic [23:0] ovf_win;                // Overflow window contents.
    logic        sync_ok;                // A start/stop may complete now.

    // ------------------------------------------------------------------
    // Avalon-MM handshake
    // ------------------------------------------------------------------
    // A request sees waitrequest high for one cycle and low in the next.
    // Read data and read side effects are taken in the first cycle, so
    // the latches fire once per access even though the master holds.
    assign reg_idx     = avs_address[5:2];
    assign wbyte       = avs_writedata[7:0];
    assign rd_take     = avs_read && avs_waitrequest;
    assign wr_take     = avs_write && !avs_waitrequest;
    assign wr_byte     = wr_take && avs_byteenable[0];
    assign m1_write    = wr_byte && (reg_idx == `RSL_OFS_M1);
    assign movf2_write = wr_byte && (reg_idx == `RSL_OFS_MOVF2);
    assign cnt_word    = {wbyte, cnt_lo_stage};
    assign ovf_word    = {wbyte, ovf_lo_stage};

    // The wait state toggles so every access takes exactly two cycles.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    // ------------------------------------------------------------------
    // Direct control registers
    // ------------------------------------------------------------------
    // Control, selects, masks and event selectors; all zero at reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            go_bit                 <= 1'b0;
            joint_latch_select     <= 1'b0;
            sync_mode              <= 1'b0;
            count_window_select    <= 3'h0;
            overflow_window_select <= 3'h0;
            irq_mask_reg           <= 8'h00;
            event_out_one_select   <= `RSL_EVT_NONE;
            event_out_two_select   <= `RSL_EVT_NONE;
        end else if (wr_byte) begin
            case (reg_idx)
                `RSL_OFS_CTRL: begin
                    go_bit             <= wbyte[`RSL_CTRL_GO];
                    joint_latch_select <= wbyte[`RSL_CTRL_LATCH];
                    sync_mode          <= wbyte[`RSL_CTRL_SYNC];
                end
                `RSL_OFS_SEL: begin
                    count_window_select    <= wbyte[`RSL_SEL_CNT_LSB +: 3];
                    overflow_window_select <= wbyte[`RSL_SEL_OVF_LSB +: 3];
                end
                `RSL_OFS_IRQM: begin
                    irq_mask_reg <= wbyte;
                end
                `RSL_OFS_EVTCFG: begin
                    event_out_one_select <= wbyte[`RSL_EVT1_LSB +: 4];
                    event_out_two_select <= wbyte[`RSL_EVT2_LSB +: 4];
                end
                default: begin
                    // Other offsets are handled by their own processes.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------------
    // With sync mode the change waits for the slow tick pulse; no reload
    // arithmetic is done, so a sync start resumes from the held values.
    assign sync_ok = !sync_mode || slow_tick; // [R3]

    always_comb begin
        next_state = state;
        case (state)
            rsl_pkg::RSL_IDLE: begin
                if (go_bit && sync_ok) begin
                    next_state = rsl_pkg::RSL_RUN; // [R1]
                end
            end
            rsl_pkg::RSL_RUN: begin
                if (!go_bit && sync_ok) begin
                    next_state = rsl_pkg::RSL_IDLE; // [R2]
                end
            end
            default: begin
                next_state = rsl_pkg::RSL_IDLE;
            end
        endcase
    end

    // The state register starts idle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= rsl_pkg::RSL_IDLE; // [R1]
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Up-counter and delta stretch
    // ------------------------------------------------------------------
    // The count only moves while running and no delta is pending.
    assign tick = (state == rsl_pkg::RSL_RUN) && (delta == 16'h0000); // [R8]

    // Byte staging: the low byte waits until the high port is written.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_lo_stage <= 8'h00;
            ovf_lo_stage <= 16'h0000;
        end else if (wr_byte) begin
            if (reg_idx == `RSL_OFS_M0) begin
                cnt_lo_stage <= wbyte; // [R6]
            end else if (reg_idx == `RSL_OFS_MOVF0) begin
                ovf_lo_stage[7:0] <= wbyte; // [R14]
            end else if (reg_idx == `RSL_OFS_MOVF1) begin
                ovf_lo_stage[15:8] <= wbyte; // [R14]
            end
        end
    end

    // The count wraps to zero in the cycle it sits at the period.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tim <= `RSL_TIM_RST; // [R22]
        end else if (m1_write && count_window_select == `RSL_WIN_COUNT
                     && state == rsl_pkg::RSL_IDLE) begin
            tim <= cnt_word; // [R6]
        end else if (tick) begin
            if (tim == tim_per) begin
                tim <= `RSL_TIM_RST; // [R7]
            end else begin
                tim <= tim + 16'h0001; // [R4]
            end
        end
    end

    // A running count write loads the delta; it then counts down to zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            delta <= 16'h0000;
        end else if (m1_write && count_window_select == `RSL_WIN_COUNT
                     && state == rsl_pkg::RSL_RUN) begin
            delta <= cnt_word; // [R8]
        end else if (state == rsl_pkg::RSL_RUN && delta != 16'h0000) begin
            delta <= delta - 16'h0001; // [R9]
        end
    end

    // Period and compare values written through the count window.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tim_per  <= `RSL_TIM_RST; // [R22]
            tim_cmp1 <= `RSL_TIM_RST;
            tim_cmp2 <= `RSL_TIM_RST;
        end else if (m1_write) begin
            case (count_window_select) // [R21]
                `RSL_WIN_PERIOD: tim_per  <= cnt_word;
                `RSL_WIN_CMP1:   tim_cmp1 <= cnt_word;
                `RSL_WIN_CMP2:   tim_cmp2 <= cnt_word;
                default: begin
                    // Count is handled above; capture and reserved are read-only.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Overflow counter
    // ------------------------------------------------------------------
    // A software write lands only when the top byte arrives.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf <= `RSL_OVF_RST; // [R22]
        end else if (movf2_write && overflow_window_select == `RSL_WIN_COUNT) begin
            ovf <= ovf_word; // [R14]
        end else if (evt.tim_ovf) begin
            if (ovf == ovf_per) begin
                ovf <= `RSL_OVF_RST; // [R15]
            end else begin
                ovf <= ovf + 24'h00_0001; // [R11]
            end
        end
    end

    // Period and compare values written through the overflow window.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf_per  <= `RSL_OVF_RST; // [R22]
            ovf_cmp1 <= `RSL_OVF_RST;
            ovf_cmp2 <= `RSL_OVF_RST;
        end else if (movf2_write) begin
            case (overflow_window_select) // [R21]
                `RSL_WIN_PERIOD: ovf_per  <= ovf_word;
                `RSL_WIN_CMP1:   ovf_cmp1 <= ovf_word; // [R16]
                `RSL_WIN_CMP2:   ovf_cmp2 <= ovf_word; // [R16]
                default: begin
                    // Counter handled above; capture and reserved are read-only.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    // The packet event takes a snapshot of both counters together.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tim_cap <= `RSL_TIM_RST; // [R22]
            ovf_cap <= `RSL_OVF_RST;
        end else if (capture_in) begin
            tim_cap <= tim; // [R18]
            ovf_cap <= ovf; // [R18]
        end
    end

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    // Overflow-counter events are tied to the timer overflow so that a
    // counter parked on a compare value does not fire every cycle.
    always_comb begin
        evt           = '0;
        evt.tim_ovf   = tick && (tim == tim_per);                      // [R7]
        evt.tim_cmp1  = tick && (tim == tim_cmp1);                     // [R10]
        evt.tim_cmp2  = tick && (tim == tim_cmp2);                     // [R10]
        evt.ovf_per   = evt.tim_ovf && (ovf == ovf_per);               // [R15]
        evt.ovf_cmp1  = evt.tim_ovf && (ovf == ovf_cmp1);              // [R16]
        evt.ovf_cmp2  = evt.tim_ovf && (ovf == ovf_cmp2);              // [R16]
        evt.long_cmp1 = tick && ({ovf, tim} == {ovf_cmp1, tim_cmp1});  // [R17]
        evt.long_cmp2 = tick && ({ovf, tim} == {ovf_cmp2, tim_cmp2});  // [R17]
    end

    // ------------------------------------------------------------------
    // Flags, interrupt and event outputs
    // ------------------------------------------------------------------
    // Writing zero clears a flag; a new event in the same cycle wins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_reg <= 8'h00;
        end else if (wr_byte && reg_idx == `RSL_OFS_IRQF) begin
            irq_flag_reg <= (irq_flag_reg & wbyte) | evt; // [R19]
        end else begin
            irq_flag_reg <= irq_flag_reg | evt; // [R19]
        end
    end

    // Registered so the output comes straight from a flop.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_flag_reg & irq_mask_reg); // [R23]
        end
    end

    // Code 0 is none; code n from 1 to 8 picks event bit n-1, codes 9 to 15 pick none. Pulses lag by one cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_out_one <= 1'b0;
            event_out_two <= 1'b0;
        end else begin
            event_out_one <= (event_out_one_select != `RSL_EVT_NONE) && // [R20]
                             (event_out_one_select <= 4'h8) &&
                             evt[3'(event_out_one_select - 4'h1)];       // [R24]
            event_out_two <= (event_out_two_select != `RSL_EVT_NONE) && // [R20]
                             (event_out_two_select <= 4'h8) &&
                             evt[3'(event_out_two_select - 4'h1)];       // [R24]
        end
    end

    // ------------------------------------------------------------------
    // Read path and latches
    // ------------------------------------------------------------------
    // Window contents; reserved codes read as zero.
    always_comb begin
        case (count_window_select) // [R21]
            `RSL_WIN_COUNT:   cnt_win = tim;
            `RSL_WIN_CAPTURE: cnt_win = tim_cap; // [R18]
            `RSL_WIN_PERIOD:  cnt_win = tim_per;
            `RSL_WIN_CMP1:    cnt_win = tim_cmp1;
            `RSL_WIN_CMP2:    cnt_win = tim_cmp2;
            default:          cnt_win = 16'h0000;
        endcase
        case (overflow_window_select) // [R21]
            `RSL_WIN_COUNT:   ovf_win = ovf;
            `RSL_WIN_CAPTURE: ovf_win = ovf_cap; // [R18]
            `RSL_WIN_PERIOD:  ovf_win = ovf_per;
            `RSL_WIN_CMP1:    ovf_win = ovf_cmp1;
            `RSL_WIN_CMP2:    ovf_win = ovf_cmp2;
            default:          ovf_win = 24'h00_0000;
        endcase
    end

    // Byte returned for the addressed port; live upper bytes go via latches.
    always_comb begin
        next_rdata = 8'h00;
        case (reg_idx)
            `RSL_OFS_CTRL: begin
                next_rdata = {4'h0, (state == rsl_pkg::RSL_RUN), sync_mode,
                              joint_latch_select, go_bit};
            end
            `RSL_OFS_SEL:    next_rdata = {1'b0, overflow_window_select,
                                           1'b0, count_window_select};
            `RSL_OFS_M0:     next_rdata = cnt_win[7:0];
            `RSL_OFS_M1: begin
                next_rdata = (count_window_select == `RSL_WIN_COUNT) ?
                             tim_hi_latch : cnt_win[15:8]; // [R5]
            end
            `RSL_OFS_MOVF0: begin
                next_rdata = (overflow_window_select == `RSL_WIN_COUNT
                              && joint_latch_select) ? ovf_lo_latch : ovf_win[7:0];
            end
            `RSL_OFS_MOVF1: begin
                next_rdata = (overflow_window_select == `RSL_WIN_COUNT) ?
                             ovf_hi_latch[7:0] : ovf_win[15:8];
            end
            `RSL_OFS_MOVF2: begin
                next_rdata = (overflow_window_select == `RSL_WIN_COUNT) ?
                             ovf_hi_latch[15:8] : ovf_win[23:16];
            end
            `RSL_OFS_IRQF:   next_rdata = irq_flag_reg;
            `RSL_OFS_IRQM:   next_rdata = irq_mask_reg;
            `RSL_OFS_EVTCFG: next_rdata = {event_out_two_select, event_out_one_select};
            default:         next_rdata = 8'h00;
        endcase
    end

    // Read data is registered in the wait cycle and held to the take edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // Latches fired by reads of the low ports with window 000.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tim_hi_latch <= 8'h00;
            ovf_hi_latch <= 16'h0000;
            ovf_lo_latch <= 8'h00;
        end else if (rd_take) begin
            if (reg_idx == `RSL_OFS_M0 && count_window_select == `RSL_WIN_COUNT) begin
                tim_hi_latch <= tim[15:8]; // [R5]
                if (joint_latch_select) begin
                    ovf_lo_latch <= ovf[7:0];   // [R12]
                    ovf_hi_latch <= ovf[23:8];  // [R12]
                end
            end else if (reg_idx == `RSL_OFS_MOVF0 && !joint_latch_select
                         && overflow_window_select == `RSL_WIN_COUNT) begin
                ovf_hi_latch <= ovf[23:8]; // [R13]
            end
        end
    end

endmodule

// >>> rsl_radio_slot_timer_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port-level checks on the bus handshake, interrupt and event outputs.
// ----------------------------------------------------------------------
module rsl_radio_slot_timer_props (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq,
    input wire logic        event_out_one,
    input wire logic        event_out_two
);
    logic wrote; // High once software has written anything since reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) wrote <= 1'b0;
        else if (avs_write) wrote <= 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("wait low too long");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("no answer");
    a_wait_rest: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("wait low at rest");
    a_data_upper: assert property (avs_readdata[31:8] == 24'h0)
        else $error("upper data set");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address[5:2] >= 4'ha
        |=> avs_readdata == 32'h0) else $error("unmapped data");
    a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("data moved");
    a_irq_clear: assert property ($fell(irq) |-> $past(avs_write, 2))
        else $error("irq fell alone");
    a_quiet_start: assert property (!wrote |-> !irq && !event_out_one && !event_out_two)
        else $error("activity before start");
endmodule

bind rsl_radio_slot_timer rsl_radio_slot_timer_props chk_u (.*);

// >>> rsl_radio_slot_timer_tb.sv
`timescale 1ns/1ps
`include "rsl_params.svh"
module rsl_radio_slot_timer_tb;
    logic        clk, nrst, avs_read, avs_write, slow_tick, capture_in;
    logic        avs_waitrequest, irq, event_out_one, event_out_two;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [7:0]  q, a, p, d, c, e2;
    logic [7:0]  v [3];
    int          err_count = 0, checked = 0, cnt = 0, gap = 0;
    rsl_radio_slot_timer dut_u (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulse-to-pulse spacing of event one, in clock cycles.
    // Event two is timed from the last event one pulse.
    always @(posedge clk) begin
        if (event_out_two === 1'b1) e2 <= 8'(cnt);
        if (event_out_one === 1'b1) begin
            gap <= cnt;
            cnt <= 1;
        end else cnt <= cnt + 1;
    end
    task automatic bus(input logic [3:0] w, input logic we, input logic [7:0] dv);
        @(posedge clk);
        {avs_address, avs_read, avs_write, avs_writedata} <= {w, 2'b00, !we, we, 24'h0, dv};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        {avs_read, avs_write} <= 2'b00;
    endtask
    task automatic wr(input logic [3:0] w, input logic [7:0] dv); bus(w, 1'b1, dv); endtask
    task automatic rd(input logic [3:0] w); bus(w, 1'b0, 8'h00); endtask
    task automatic pulse;
        @(posedge clk);
        while (event_out_one !== 1'b1) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Cycles from one wrap to the next, or from a wrap to a compare hit.
    function automatic logic [7:0] gap_of(input logic [7:0] n, input logic [7:0] dl);
        return n + 8'h01 + dl;
    endfunction
    task automatic give_verdict;
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Whole run needs well under 2000 cycles; this bound only cuts a hang.
    initial begin
        #60000;
        err_count++;
        give_verdict();
    end
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {slow_tick, capture_in, avs_byteenable} = 6'h0f;
        void'($urandom(34));
        p = 8'h10 + 8'($urandom % 32);
        d = 8'h01 + 8'($urandom % 16);
        c = 8'h01 + 8'($urandom % 8);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(`RSL_OFS_CTRL); chk(q, 8'h00);
        rd(`RSL_OFS_M0); chk(q, 8'h00);
        rd(4'ha); chk(q, 8'h00);
        wr(`RSL_OFS_SEL, 8'h02); wr(`RSL_OFS_M0, p); wr(`RSL_OFS_M1, 8'h00);
        rd(`RSL_OFS_M0); chk(q, p);
        wr(`RSL_OFS_SEL, 8'h03); wr(`RSL_OFS_M0, c); wr(`RSL_OFS_M1, 8'h00);
        wr(`RSL_OFS_IRQM, 8'h01); wr(`RSL_OFS_EVTCFG, 8'h21); wr(`RSL_OFS_CTRL, 8'h01);
        pulse(); pulse(); chk(8'(gap), gap_of(p, 8'h00));
        chk({7'h0, irq}, 8'h01);
        wr(`RSL_OFS_SEL, 8'h00); wr(`RSL_OFS_M0, d); wr(`RSL_OFS_M1, 8'h00);
        pulse(); chk(8'(gap), gap_of(p, d));
        pulse(); chk(8'(gap), gap_of(p, 8'h00));
        wr(`RSL_OFS_CTRL, 8'h00);
        chk(e2, gap_of(c, 8'h00));
        rd(`RSL_OFS_IRQF); chk(q & 8'h03, 8'h03);
        wr(`RSL_OFS_IRQF, 8'h00); rd(`RSL_OFS_IRQF); chk(q, 8'h00);
        chk({7'h0, irq}, 8'h00);
        rd(`RSL_OFS_M0); a = q; rd(`RSL_OFS_M0); chk(q, a);
        foreach (v[i]) v[i] = 8'($urandom);
        wr(`RSL_OFS_M0, v[0]); wr(`RSL_OFS_M1, v[1]);
        rd(`RSL_OFS_M0); chk(q, v[0]);
        rd(`RSL_OFS_M1); chk(q, v[1]);
        for (int i = 0; i < 3; i++) wr(`RSL_OFS_MOVF0 + 4'(i), v[i]);
        for (int i = 0; i < 3; i++) begin
            rd(`RSL_OFS_MOVF0 + 4'(i)); chk(q, v[i]);
        end
        @(posedge clk) capture_in <= 1'b1;
        @(posedge clk) capture_in <= 1'b0;
        wr(`RSL_OFS_SEL, 8'h11); rd(`RSL_OFS_M0); chk(q, v[0]);
        rd(`RSL_OFS_MOVF2); chk(q, v[2]);
        wr(`RSL_OFS_CTRL, 8'h05); rd(`RSL_OFS_CTRL); chk(q, 8'h05);
        @(posedge clk) slow_tick <= 1'b1;
        @(posedge clk) slow_tick <= 1'b0;
        rd(`RSL_OFS_CTRL); chk(q, 8'h0d);
        give_verdict();
    end
endmodule
